// >>> pkg/tcos_pkg.sv
// Purpose: shared constants of the complementary output stage
// Assumes: 32-bit classic wishbone register port
// Notes: all registers reset to zero
package tcos_pkg;
   localparam int NCH = 4;
   localparam int NCOMP = 3;
   localparam int CNT_W = 16;
   localparam int DT_W = 8;
   localparam int AW = 8;
   // compare output mode codes
   localparam logic [2:0] MODE_KEEP = 3'h0;
   localparam logic [2:0] MODE_SET = 3'h1;
   localparam logic [2:0] MODE_CLR = 3'h2;
   localparam logic [2:0] MODE_TOG = 3'h3;
   localparam logic [2:0] MODE_FLO = 3'h4;
   localparam logic [2:0] MODE_FHI = 3'h5;
   localparam logic [2:0] MODE_PWM0 = 3'h6;
   localparam logic [2:0] MODE_PWM1 = 3'h7;
   // register byte offsets
   localparam logic [AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AW-1:0] REG_CHCFG = 8'h04;
   localparam logic [AW-1:0] REG_IDLE = 8'h08;
   localparam logic [AW-1:0] REG_STAT = 8'h0c;
   localparam logic [AW-1:0] REG_CV0 = 8'h10;
   // control register fields
   localparam int F_MOE = 0;
   localparam int F_ROS = 1;
   localparam int F_IOS = 2;
   localparam int F_DT = 8;
   // per-channel config byte fields
   localparam int CH_STRIDE = 8;
   localparam int F_MODE = 0;
   localparam int F_CLR = 3;
   localparam int F_PEN = 4;
   localparam int F_NEN = 5;
   localparam int F_PP = 6;
   localparam int F_NP = 7;
   // idle and status fields
   localparam int F_IDLE_N = 4;
   localparam int F_ST_MOE = 4;
   localparam int F_ST_P = 8;
   localparam int F_ST_N = 12;
   localparam logic [31:0] REG_RST = 32'h0;
endpackage : tcos_pkg

// >>> core/tcos_prepare.sv
// Purpose: per-channel output prepare signal
// Assumes: counter, compare and update come from the timer clock domain
// Notes: prepare level is registered, one clock after the match
`timescale 1ns/1ns
module tcos_prepare #(
   parameter int CNT_W = tcos_pkg::CNT_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // configuration
   input wire logic [2:0] mode_i,
   input wire logic clear_en_i,
   input wire logic [CNT_W-1:0] compare_i,
   // timer state
   input wire logic [CNT_W-1:0] counter_i,
   input wire logic [CNT_W-1:0] reload_i,
   input wire logic count_down_i,
   input wire logic update_evt_i,
   input wire logic ext_trig_i,
   // prepare level
   output logic prep_o
);
   import tcos_pkg::*;
   logic prep_r, prep_nxt, hold_r, kill, match, act, over;

   // match, pwm comparison and overrange
   assign match = counter_i == compare_i;
   assign act = count_down_i ? (counter_i <= compare_i) : (counter_i < compare_i);
   assign over = !count_down_i && (compare_i > reload_i);
   assign kill = clear_en_i && ext_trig_i;

   // next prepare level by mode
   always_comb begin
      case (mode_i)
         MODE_KEEP: prep_nxt = prep_r;
         MODE_SET: prep_nxt = match ? 1'b1 : prep_r;
         MODE_CLR: prep_nxt = match ? 1'b0 : prep_r;
         MODE_TOG: prep_nxt = match ? !prep_r : prep_r;
         MODE_FLO: prep_nxt = 1'b0;
         MODE_FHI: prep_nxt = 1'b1;
         MODE_PWM0: prep_nxt = over ? 1'b0 : act;
         MODE_PWM1: prep_nxt = over ? 1'b1 : !act;
         default: prep_nxt = prep_r;
      endcase
   end

   // clear latch, released by the update event
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_r <= 1'b0;
      end else if (kill) begin
         hold_r <= 1'b1;
      end else if (update_evt_i) begin
         hold_r <= 1'b0;
      end
   end

   // registered prepare level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prep_r <= 1'b0;
      end else begin
         prep_r <= (kill || hold_r) ? 1'b0 : prep_nxt;
      end
   end
   assign prep_o = prep_r;

   a_set_on_match: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == MODE_SET && match && !kill && !hold_r) |=> prep_r)
      else $error("prepare not set on match");
   a_toggle_match: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == MODE_TOG && match && !kill && !hold_r) |=> prep_r != $past(prep_r))
      else $error("prepare not toggled on match");
   a_forced_high: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == MODE_FHI && !kill && !hold_r) |=> prep_r)
      else $error("forced active level missing");
   a_ext_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      kill |=> !prep_r && hold_r)
      else $error("external clear did not force low");
   a_clear_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      (hold_r && !update_evt_i) |=> hold_r && !prep_r)
      else $error("prepare left clear before update");
   a_pwm_range: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == MODE_PWM0 && over && !kill && !hold_r) |=> !prep_r)
      else $error("pwm0 active with compare above reload");
   c_clear_release: cover property (@(posedge clk_i) disable iff (rst_i)
      kill ##1 hold_r ##[1:50] update_evt_i);
endmodule : tcos_prepare

// >>> core/tcos_outstage.sv
// Purpose: output pair with polarity, enables, off-state and dead time
// Assumes: prepare level and controls are on the timer clock
// Notes: dead time of n gives n+1 clocks with both outputs inactive, n+2 clocks from prepare edge to the delayed output
`timescale 1ns/1ns
module tcos_outstage #(
   parameter bit HAS_COMP = 1'b1,
   parameter int DT_W = tcos_pkg::DT_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // prepare level and controls
   input wire logic prep_i,
   input wire logic pen_i,
   input wire logic nen_i,
   input wire logic ppol_i,
   input wire logic npol_i,
   input wire logic moe_i,
   input wire logic ros_i,
   input wire logic ios_i,
   input wire logic idle_p_i,
   input wire logic idle_n_i,
   input wire logic [DT_W-1:0] deadtime_i,
   // output pair with enables
   output logic pout_o,
   output logic poe_o,
   output logic nout_o,
   output logic noe_o
);
   import tcos_pkg::*;
   logic nen, prep_d_r, moe_d_r, edg, moe_fall, insert, p_act, n_act;
   logic p_nxt, pe_nxt, n_nxt, ne_nxt;
   logic [DT_W-1:0] dt, cnt_r;

   // single-ended channel has no complement and no dead time
   assign nen = HAS_COMP ? nen_i : 1'b0;
   assign dt = HAS_COMP ? deadtime_i : '0;
   assign edg = prep_i ^ prep_d_r;
   assign moe_fall = moe_d_r && !moe_i;
   assign insert = pen_i && nen && moe_i;

   // edge history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prep_d_r <= 1'b0;
         moe_d_r <= 1'b0;
      end else begin
         prep_d_r <= prep_i;
         moe_d_r <= moe_i;
      end
   end

   // dead time down-counter, reloaded on a prepare edge while master enable is high and on master enable fall
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else if ((edg && moe_i) || moe_fall) begin
         cnt_r <= dt;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // delayed active phases, short pulses never reach the primary
   assign p_act = prep_i && (!insert || (prep_d_r && cnt_r == '0));
   assign n_act = !prep_i && (!insert || (!prep_d_r && cnt_r == '0));

   // output selection
   always_comb begin
      p_nxt = 1'b0;
      pe_nxt = 1'b0;
      n_nxt = 1'b0;
      ne_nxt = 1'b0;
      if (moe_i) begin
         if (pen_i) begin
            p_nxt = p_act ^ ppol_i;
            pe_nxt = 1'b1;
         end else if (ros_i) begin
            p_nxt = ppol_i;
            pe_nxt = 1'b1;
         end
         if (nen) begin
            n_nxt = n_act ^ npol_i;
            ne_nxt = 1'b1;
         end else if (ros_i) begin
            n_nxt = npol_i;
            ne_nxt = 1'b1;
         end
      end else if (ios_i || pen_i || nen) begin
         pe_nxt = 1'b1;
         ne_nxt = 1'b1;
         if (cnt_r == '0 && !moe_fall) begin
            p_nxt = idle_p_i;
            n_nxt = idle_n_i;
         end else begin
            p_nxt = ppol_i;
            n_nxt = npol_i;
         end
      end
   end

   // registered pins, disabled pins released
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pout_o <= 1'b0;
         poe_o <= 1'b0;
         nout_o <= 1'b0;
         noe_o <= 1'b0;
      end else begin
         pout_o <= p_nxt;
         poe_o <= pe_nxt;
         nout_o <= HAS_COMP && n_nxt;
         noe_o <= HAS_COMP && ne_nxt;
      end
   end

   a_no_overlap: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(insert) |-> !((pout_o ^ $past(ppol_i)) && (nout_o ^ $past(npol_i))))
      else $error("both outputs active together");
   a_rise_comp_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      (insert && prep_i && !prep_d_r) |=> nout_o == $past(npol_i) && pout_o == $past(ppol_i))
      else $error("rise did not clear complement at once");
   a_fall_prim_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      (insert && !prep_i && prep_d_r) |=> pout_o == $past(ppol_i) && nout_o == $past(npol_i))
      else $error("fall did not clear primary at once");
   a_run_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
      (moe_i && !pen_i && !ros_i) |=> !poe_o && !pout_o)
      else $error("disabled output still driven");
   a_run_offstate: assert property (@(posedge clk_i) disable iff (rst_i)
      (moe_i && !pen_i && ros_i) |=> poe_o && pout_o == $past(ppol_i))
      else $error("off-state level wrong");
   a_run_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      (moe_i && pen_i && !nen) |=> poe_o && pout_o == $past(prep_i ^ ppol_i))
      else $error("primary does not follow prepare");
   a_off_first: assert property (@(posedge clk_i) disable iff (rst_i)
      (moe_fall && (ios_i || pen_i || nen)) |=> poe_o && pout_o == $past(ppol_i))
      else $error("off entry not inactive first");
   c_dead_rise: cover property (@(posedge clk_i) disable iff (rst_i)
      (insert && prep_i && !prep_d_r && dt != '0) ##[2:300] (pout_o != ppol_i));
   c_idle_entry: cover property (@(posedge clk_i) disable iff (rst_i)
      moe_fall ##[1:300] (poe_o && cnt_r == '0));
endmodule : tcos_outstage

// >>> core/tcos_top.sv
// Purpose: timer complementary output stage with wishbone registers
// Assumes: counter, reload, direction and update come from timer logic on clk_i
// Notes: trigger and break pins pass a two-stage synchroniser
//
// Function
// - on match the prepare level keeps, sets, clears or toggles per mode 0..3
// - modes 6 and 7 follow direction and counter versus compare
// - modes 4 and 5 force the prepare level inactive or active
// - clear enable with high external trigger forces prepare low
// - after an external clear prepare stays low until the next update
// - only channels 0 to 2 have complement and dead time, channel 3 not
// - primary and complement of one channel never active together while master enable is high; idle levels may set both
// - running with off-state select low, a disabled output is released from its pin
// - master enable low: inactive levels first, idle levels after one dead time
// - running, enabled outputs are prepare xor polarity, complement uses inverted prepare
// - running with off-state select high, a disabled output drives its polarity
// - dead time only when both enables and master enable are high
// - one dead time field serves channels 0 to 2, not channel 3
// - on prepare rise complement clears now, primary waits the dead time
// - on prepare fall primary clears now, complement waits the dead time
// - dead time not shorter than the pulse keeps the primary inactive
// - up counting with compare above reload: pwm0 inactive, pwm1 active
// - a break clears master enable, outputs then take the off behaviour
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ns
module tcos_top #(
   parameter int CNT_W = tcos_pkg::CNT_W,
   parameter int DT_W = tcos_pkg::DT_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tcos_pkg::AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // timer counter side
   input wire logic [CNT_W-1:0] counter_i,
   input wire logic [CNT_W-1:0] autoreload_value_i,
   input wire logic count_down_i,
   input wire logic update_evt_i,
   // asynchronous pins
   input wire logic filtered_ext_trigger_i,
   input wire logic break_pin_i,
   // output pins
   output logic [tcos_pkg::NCH-1:0] primary_out_o,
   output logic [tcos_pkg::NCH-1:0] primary_out_oe_o,
   output logic [tcos_pkg::NCOMP-1:0] complement_out_o,
   output logic [tcos_pkg::NCOMP-1:0] complement_out_oe_o
);
   import tcos_pkg::*;

   if (CNT_W < 2 || CNT_W > 32 || DT_W < 1 || DT_W > 8) begin : g_bad_width
      $error("unsupported counter or dead time width");
   end

   logic ack_r, acc, wr, master_output_enable_r;
   logic run_offstate_select_r, idle_offstate_select_r;
   logic trig_s1_r, trig_s2_r, brk_s1_r, brk_s2_r;
   logic [DT_W-1:0] deadtime_config_r;
   logic [31:0] chcfg_r, idle_r, rdata_r;
   logic [CNT_W-1:0] cv_r [NCH];
   logic [NCH-1:0] prep, pout, poe, nout, noe;

   // byte-lane merge of a write
   function automatic logic [31:0] bmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction : bmerge

   // compare value decode, -1 when not a compare register
   function automatic int cv_index(input logic [AW-1:0] adr);
      int idx;
      idx = -1;
      for (int c = 0; c < NCH; c++) begin
         if (adr == REG_CV0 + AW'(4 * c)) begin
            idx = c;
         end
      end
      return idx;
   endfunction : cv_index

   // bus access strobes, one ack per request
   assign acc = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr = acc && wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= acc;
      end
   end
   assign wb_ack_o = ack_r;

   // pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         brk_s1_r <= 1'b0;
         brk_s2_r <= 1'b0;
      end else begin
         trig_s1_r <= filtered_ext_trigger_i;
         trig_s2_r <= trig_s1_r;
         brk_s1_r <= break_pin_i;
         brk_s2_r <= brk_s1_r;
      end
   end

   // master output enable, break wins over a write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_output_enable_r <= REG_RST[F_MOE];
      end else if (brk_s2_r) begin
         master_output_enable_r <= 1'b0;
      end else if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
         master_output_enable_r <= wb_dat_i[F_MOE];
      end
   end

   // off-state selects and shared dead time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_offstate_select_r <= REG_RST[F_ROS];
         idle_offstate_select_r <= REG_RST[F_IOS];
         deadtime_config_r <= REG_RST[F_DT +: DT_W];
      end else if (wr && wb_adr_i == REG_CTRL) begin
         if (wb_sel_i[0]) begin
            run_offstate_select_r <= wb_dat_i[F_ROS];
            idle_offstate_select_r <= wb_dat_i[F_IOS];
         end
         if (wb_sel_i[1]) begin
            deadtime_config_r <= wb_dat_i[F_DT +: DT_W];
         end
      end
   end

   // channel configuration and idle levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chcfg_r <= REG_RST;
         idle_r <= REG_RST;
      end else if (wr && wb_adr_i == REG_CHCFG) begin
         chcfg_r <= bmerge(chcfg_r, wb_dat_i, wb_sel_i);
      end else if (wr && wb_adr_i == REG_IDLE) begin
         idle_r <= bmerge(idle_r, wb_dat_i, wb_sel_i);
      end
   end

   // compare values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            cv_r[c] <= REG_RST[CNT_W-1:0];
         end
      end else if (wr && cv_index(wb_adr_i) >= 0) begin
         cv_r[cv_index(wb_adr_i)] <= CNT_W'(bmerge(32'(cv_r[cv_index(wb_adr_i)]),
            wb_dat_i, wb_sel_i));
      end
   end

   // read data, unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_r <= REG_RST;
      end else if (acc) begin
         rdata_r <= '0;
         if (wb_adr_i == REG_CTRL) begin
            rdata_r[F_MOE] <= master_output_enable_r;
            rdata_r[F_ROS] <= run_offstate_select_r;
            rdata_r[F_IOS] <= idle_offstate_select_r;
            rdata_r[F_DT +: DT_W] <= deadtime_config_r;
         end else if (wb_adr_i == REG_CHCFG) begin
            rdata_r <= chcfg_r;
         end else if (wb_adr_i == REG_IDLE) begin
            rdata_r <= idle_r;
         end else if (wb_adr_i == REG_STAT) begin
            rdata_r[NCH-1:0] <= prep;
            rdata_r[F_ST_MOE] <= master_output_enable_r;
            rdata_r[F_ST_P +: NCH] <= pout;
            rdata_r[F_ST_N +: NCH] <= nout;
         end else if (cv_index(wb_adr_i) >= 0) begin
            rdata_r[CNT_W-1:0] <= cv_r[cv_index(wb_adr_i)];
         end
      end
   end
   assign wb_dat_o = rdata_r;

   // per-channel prepare and output stages
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      tcos_prepare #(.CNT_W(CNT_W)) u_prep (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .mode_i(chcfg_r[i*CH_STRIDE + F_MODE +: 3]),
         .clear_en_i(chcfg_r[i*CH_STRIDE + F_CLR]),
         .compare_i(cv_r[i]),
         .counter_i(counter_i),
         .reload_i(autoreload_value_i),
         .count_down_i(count_down_i),
         .update_evt_i(update_evt_i),
         .ext_trig_i(trig_s2_r),
         .prep_o(prep[i])
      );
      tcos_outstage #(.HAS_COMP(i < NCOMP), .DT_W(DT_W)) u_out (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .prep_i(prep[i]),
         .pen_i(chcfg_r[i*CH_STRIDE + F_PEN]),
         .nen_i(chcfg_r[i*CH_STRIDE + F_NEN]),
         .ppol_i(chcfg_r[i*CH_STRIDE + F_PP]),
         .npol_i(chcfg_r[i*CH_STRIDE + F_NP]),
         .moe_i(master_output_enable_r),
         .ros_i(run_offstate_select_r),
         .ios_i(idle_offstate_select_r),
         .idle_p_i(idle_r[i]),
         .idle_n_i(idle_r[F_IDLE_N + i]),
         .deadtime_i(deadtime_config_r),
         .pout_o(pout[i]),
         .poe_o(poe[i]),
         .nout_o(nout[i]),
         .noe_o(noe[i])
      );
   end

   // pin outputs, channel 3 has the primary only
   assign primary_out_o = pout;
   assign primary_out_oe_o = poe;
   assign complement_out_o = nout[NCOMP-1:0];
   assign complement_out_oe_o = noe[NCOMP-1:0];

   a_break_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      brk_s2_r |=> !master_output_enable_r ##1 (primary_out_o == 
      (primary_out_oe_o & primary_out_o)))
      else $error("break did not clear master enable");
   a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one cycle after request");
   c_break_seen: cover property (@(posedge clk_i) disable iff (rst_i)
      master_output_enable_r ##1 brk_s2_r ##1 !master_output_enable_r);

   // channel 3 has no complement path, so its complement stays released
   a_ch3_single: assert property (@(posedge clk_i) disable iff (rst_i)
      !noe[NCH-1] && !nout[NCH-1])
      else $error("channel 3 complement driven");

   // a master enable write lands unless a break is pending in the same cycle
   a_moe_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && !brk_s2_r) |=>
      master_output_enable_r == $past(wb_dat_i[F_MOE]))
      else $error("master enable write lost");

   // synchronised trigger with clear enable forces channel 0 low
   a_trig_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (trig_s2_r && chcfg_r[F_CLR]) |=> !prep[0])
      else $error("trigger did not clear channel 0");
endmodule : tcos_top

// >>> verification/tcos_power_stage.sv
// Purpose: power switch pair model behind the channel 0..2 output pins
// Assumes: gates are active high and pins are pulled low when released
// Notes: overlap flag is sticky until the end of the run
`timescale 1ns/1ns
module tcos_power_stage (
   // clock
   input wire logic clk_i,
   // output pins
   input wire logic [2:0] p_i,
   input wire logic [2:0] poe_i,
   input wire logic [2:0] n_i,
   input wire logic [2:0] noe_i,
   // gate levels and overlap flag
   output logic [2:0] hi_o,
   output logic [2:0] lo_o,
   output logic shoot_o
);
   // a released pin falls to the pull-down level
   assign hi_o = p_i & poe_i;
   assign lo_o = n_i & noe_i;
   // high and low side on together would short the supply
   initial shoot_o = 1'b0;
   always @(posedge clk_i) if ((hi_o & lo_o) != 3'h0) shoot_o <= 1'b1;
endmodule : tcos_power_stage

// >>> verification/timer_complementary_output_stage_test.sv
// Purpose: self-checking bench of the complementary output stage
// Assumes: channel 0 to 2 pins feed the power stage model
// Notes: polarities zero unless a scenario says otherwise
`timescale 1ns/1ns
module timer_complementary_output_stage_test;
   import tcos_pkg::*;
   // stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [15:0] cnt = 16'h0, arr = 16'h000a;
   logic down = 1'b0, upd = 1'b0, trig = 1'b0, brk = 1'b0, shoot, seen = 1'b0;
   logic [3:0] pout, poe;
   logic [2:0] nout, noe, hi, lo;
   logic [2:0] mtab [7] = '{MODE_SET, MODE_KEEP, MODE_TOG, MODE_TOG, MODE_CLR, MODE_FHI, MODE_FLO};
   logic [6:0] etab = 7'h2b;
   int fails = 0, checked = 0, n;
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (hi[0] === 1'b1) seen <= 1'b1;
   // design and far side
   tcos_top i_tcos_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .counter_i(cnt), .autoreload_value_i(arr), .count_down_i(down),
      .update_evt_i(upd), .filtered_ext_trigger_i(trig), .break_pin_i(brk),
      .primary_out_o(pout), .primary_out_oe_o(poe), .complement_out_o(nout),
      .complement_out_oe_o(noe));
   tcos_power_stage i_tcos_power_stage (.clk_i(clk_i), .p_i(pout[2:0]), .poe_i(poe[2:0]),
      .n_i(nout), .noe_i(noe), .hi_o(hi), .lo_o(lo), .shoot_o(shoot));
   // verdict and common helpers
   task give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : tick
   // classic single cycle, held until ack is sampled
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      k = 0;
      do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 16);
      if (ack !== 1'b1) begin fails++; give_verdict(); end
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb
   task until_hi(input logic v);
      n = 0;
      while (hi[0] !== v && n < 30) begin tick(1); n++; end
      if (n == 30) begin fails++; give_verdict(); end
   endtask : until_hi
   // cycles with both sides off around a prepare edge
   task gap(input logic rise);
      n = 0;
      while ((rise ? lo[0] : hi[0]) !== 1'b0 && n < 30) begin tick(1); n++; end
      n = 0;
      while ((rise ? hi[0] : lo[0]) !== 1'b1 && n < 30) begin tick(1); n++; end
   endtask : gap
   task hit(input logic [15:0] c, input logic d);
      @(posedge clk_i); cnt <= c; down <= d;
      @(posedge clk_i); cnt <= 16'h0;
      tick(3);
   endtask : hit
   // reset values, readback, unmapped place
   task t_regs;
      chk({poe, noe}, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0); chk(q, REG_RST);
      wb(1'b1, REG_CTRL, 32'h401); wb(1'b0, REG_CTRL, 32'h0); chk(q, 32'h401);
      wb(1'b1, 8'h40, 32'hffffffff); wb(1'b0, 8'h40, 32'h0); chk(q, 32'h0);
   endtask : t_regs
   // match modes and forced modes
   task t_modes;
      wb(1'b1, REG_CV0, 32'h5);
      for (int i = 0; i < 7; i++) begin
         wb(1'b1, REG_CHCFG, {29'h2, mtab[i]});
         hit(16'h5, 1'b0);
         chk(hi[0], etab[i]);
      end
   endtask : t_modes
   task pwm(input logic [2:0] m, input logic [15:0] cv, c, input logic d, e);
      wb(1'b1, REG_CV0, {16'h0, cv});
      wb(1'b1, REG_CHCFG, {29'h2, m});
      @(posedge clk_i); cnt <= c; down <= d;
      tick(3);
      chk(hi[0], e);
   endtask : pwm
   // dead time on both edges, and a pulse shorter than it
   task t_dead;
      wb(1'b1, REG_CHCFG, 32'h34); tick(8);
      chk({hi[0], lo[0]}, 32'h1);
      wb(1'b1, REG_CHCFG, 32'h35); gap(1'b1);
      chk(n, 32'h5);
      wb(1'b1, REG_CHCFG, 32'h34); gap(1'b0);
      chk(n, 32'h5);
      tick(8); seen = 1'b0;
      wb(1'b1, REG_CHCFG, 32'h35); wb(1'b1, REG_CHCFG, 32'h34); tick(10);
      chk(seen, 32'h0);
   endtask : t_dead
   // run off-state select low then high
   task t_off;
      wb(1'b1, REG_CHCFG, 32'h94); tick(3);
      chk({noe[0], nout[0], lo[0]}, 32'h0);
      wb(1'b1, REG_CTRL, 32'h403); tick(3);
      chk({noe[0], nout[0]}, 32'h3);
   endtask : t_off
   // trigger clear held until update
   task t_clear;
      wb(1'b1, REG_CTRL, 32'h401); wb(1'b1, REG_CHCFG, 32'h1d); tick(3);
      chk(hi[0], 32'h1);
      @(posedge clk_i); trig <= 1'b1; tick(5);
      chk(hi[0], 32'h0);
      @(posedge clk_i); trig <= 1'b0; tick(5);
      chk(hi[0], 32'h0);
      @(posedge clk_i); upd <= 1'b1;
      @(posedge clk_i); upd <= 1'b0; tick(3);
      chk(hi[0], 32'h1);
   endtask : t_clear
   // break: inactive first, idle levels one dead time later
   task t_break;
      wb(1'b1, REG_CTRL, 32'h205); wb(1'b1, REG_IDLE, 32'h1);
      wb(1'b1, REG_CHCFG, 32'h35); tick(10);
      @(posedge clk_i); brk <= 1'b1;
      until_hi(1'b0);
      chk(lo[0], 32'h0);
      until_hi(1'b1);
      chk({n, noe[0], lo[0]}, {32'h3, 2'b10});
      wb(1'b0, REG_CTRL, 32'h0); chk(q[0], 32'h0);
      @(posedge clk_i); brk <= 1'b0;
   endtask : t_break
   // main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_modes();
      pwm(MODE_PWM0, 16'h5, 16'h3, 1'b0, 1'b1);
      pwm(MODE_PWM0, 16'h5, 16'h7, 1'b0, 1'b0);
      pwm(MODE_PWM1, 16'h5, 16'h3, 1'b0, 1'b0);
      pwm(MODE_PWM0, 16'h5, 16'h5, 1'b1, 1'b1);
      pwm(MODE_PWM1, 16'h5, 16'h5, 1'b1, 1'b0);
      pwm(MODE_PWM0, 16'hc, 16'h3, 1'b0, 1'b0);
      pwm(MODE_PWM1, 16'hc, 16'h3, 1'b0, 1'b1);
      t_dead();
      t_off();
      t_clear();
      t_break();
      chk(shoot, 32'h0);
      give_verdict();
   end
endmodule : timer_complementary_output_stage_test
